// ### rtl/eeprom_i2c_defines.svh
// Purpose: Shared constants for the serial EEPROM two-wire target
// Assumes: Included by bare name from the design files
// Notes: Offsets, widths and timing counts only; types live in the package
`ifndef EEPROM_I2C_DEFINES_SVH
`define EEPROM_I2C_DEFINES_SVH

// =====================================================================
// Array geometry
`define EE_ADDR_W 13
`define EE_PAGE_BYTES 32
`define EE_PAGE_IDX_W 5
`define EE_HI_USED_W 5

// =====================================================================
// Target address byte fields
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_CS_MSB 3
`define EE_CS_LSB 1
`define EE_RW_BIT 0
`define EE_BYTE_LAST 4'h7
`define EE_ACK_SLOT 4'h8

// =====================================================================
// Timing
`define EE_CLK_PERIOD_NS 20
`define EE_WRITE_TIME_NS 5000000
`define EE_WRITE_CYCLES (`EE_WRITE_TIME_NS / `EE_CLK_PERIOD_NS)

`endif

// ### rtl/eeprom_i2c_pkg.sv
// Purpose: Types for the serial EEPROM two-wire target
// Assumes: Constants come from eeprom_i2c_defines.svh
// Notes: Widths fixed at the array size of 8192 bytes
`include "eeprom_i2c_defines.svh"

// =====================================================================
// Package
package eeprom_i2c_pkg;
  typedef logic [`EE_ADDR_W-1:0] word_addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [`EE_PAGE_IDX_W-1:0] page_idx_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_HI, ST_LO, ST_WDATA, ST_RDATA, ST_PROG
  } state_t;
endpackage : eeprom_i2c_pkg

// ### rtl/serial_eeprom_i2c_target.sv
// Purpose: Two-wire target logic of an 8K x 8 serial EEPROM
// Assumes: Array read port answers memRdData for memAddr in the same cycle
// Notes: SCL and SDA are sampled by core_clk; the cell array is outside
//
// Contract
// - Page write starts as byte write and may carry up to 32 data bytes.
// - Each data byte is acked and only the low five address bits increment.
// - Page address past the last byte wraps to that page's first byte.
// - Over 32 bytes wrap the page buffer, overwriting earlier positions.
// - Stop after write data starts one programming cycle committing the page.
// - While programming, all bus inputs are ignored.
// - Address is not acked while programming; acked once finished.
// - Read begins like write with direction bit one; three read kinds.
// - Address counter holds last accessed byte address plus one.
// - Read-direction address is acked, then byte at counter shifted out.
// - Counter past the top returns the byte at location zero.
// - After repeated Start and read address, device sends addressed byte.
// - Each master ack in sequential read moves on to the next byte.
// - Sequential read wraps from array top to address zero seamlessly.
// - Address byte: four type bits, three chip-select bits, direction bit.
// - Byte write acks address byte, both address bytes, one data byte.
// - Any Start aborts a partial transfer and awaits an address byte.
`timescale 1ns/100ps
`include "eeprom_i2c_defines.svh"

module serial_eeprom_i2c_target #(
  // Arbitrary neutral device-type code, set per system
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int unsigned PROG_CYCLES = `EE_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Two-wire bus
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Chip-select straps
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  // Cell array port
  output eeprom_i2c_pkg::word_addr_t memAddr,
  input wire eeprom_i2c_pkg::byte_t memRdData,
  output logic memWrEn,
  output eeprom_i2c_pkg::word_addr_t memWrAddr,
  output eeprom_i2c_pkg::byte_t memWrData,
  // Status
  output logic busy
);
  import eeprom_i2c_pkg::*;

  // ===================================================================
  // Helpers
  // Page-internal increment keeps the page bits fixed
  function automatic word_addr_t pageInc(input word_addr_t a);
    pageInc = {a[`EE_ADDR_W-1:`EE_PAGE_IDX_W], page_idx_t'(a[`EE_PAGE_IDX_W-1:0] + 5'h01)};
  endfunction : pageInc

  // ===================================================================
  // Input synchronisers
  logic [1:0] sync1Reg;
  logic [1:0] sync2Reg;
  logic [1:0] lastReg;
  logic [2:0] csS1Reg;
  logic [2:0] csS2Reg;

  // Two stages per pin; logic reads the second stage and, for SCL and SDA, its delayed copy in lastReg
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1Reg <= 2'h3;
      sync2Reg <= 2'h3;
      lastReg <= 2'h3;
      csS1Reg <= 3'h0;
      csS2Reg <= 3'h0;
    end
    else
    begin
      sync1Reg <= {scl, sdaIn};
      sync2Reg <= sync1Reg;
      lastReg <= sync2Reg;
      csS1Reg <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
      csS2Reg <= csS1Reg;
    end
  end

  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // Bus events; SDA moving while SCL is high marks Start or Stop
  assign sclS = sync2Reg[1];
  assign sdaS = sync2Reg[0];
  assign sclRise = sclS && !lastReg[1];
  assign sclFall = !sclS && lastReg[1];
  assign startSeen = sclS && lastReg[1] && lastReg[0] && !sdaS;
  assign stopSeen = sclS && lastReg[1] && !lastReg[0] && sdaS;

  // ===================================================================
  // Protocol engine state
  state_t state_reg, state_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic ackPhase_reg, ackPhase_next;
  logic goRead_reg, goRead_next;
  logic mAck_reg, mAck_next;
  byte_t shift_reg, shift_next;
  byte_t addrHi_reg, addrHi_next;
  word_addr_t addrCnt_reg, addrCnt_next;
  logic sdaOe_reg, sdaOe_next;
  logic pending_reg, pending_next;
  logic [`EE_ADDR_W-`EE_PAGE_IDX_W-1:0] pageBase_reg, pageBase_next;
  byte_t pageBuf_reg [`EE_PAGE_BYTES];
  byte_t pageBuf_next [`EE_PAGE_BYTES];
  logic [`EE_PAGE_BYTES-1:0] pageVal_reg, pageVal_next;
  logic [31:0] progCnt_reg, progCnt_next;
  logic memWrEn_reg, memWrEn_next;
  word_addr_t memWrAddr_reg, memWrAddr_next;
  byte_t memWrData_reg, memWrData_next;

  logic devHit;
  page_idx_t commitIdx;

  assign devHit = shift_reg[`EE_TYPE_MSB:`EE_TYPE_LSB] == DEV_TYPE &&
                  shift_reg[`EE_CS_MSB:`EE_CS_LSB] == csS2Reg;
  assign commitIdx = progCnt_reg[`EE_PAGE_IDX_W-1:0];

  // Next-state logic for the whole transfer engine
  always_comb
  begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    ackPhase_next = ackPhase_reg;
    goRead_next = goRead_reg;
    mAck_next = mAck_reg;
    shift_next = shift_reg;
    addrHi_next = addrHi_reg;
    addrCnt_next = addrCnt_reg;
    sdaOe_next = sdaOe_reg;
    pending_next = pending_reg;
    pageBase_next = pageBase_reg;
    pageBuf_next = pageBuf_reg;
    pageVal_next = pageVal_reg;
    progCnt_next = progCnt_reg;
    memWrEn_next = 1'b0;
    memWrAddr_next = memWrAddr_reg;
    memWrData_next = memWrData_reg;
    if (state_reg == ST_PROG)
    begin
      // Bus is deaf here, so polling addresses get no ack
      if (progCnt_reg < `EE_PAGE_BYTES)
      begin
        memWrEn_next = pageVal_reg[commitIdx];
        memWrAddr_next = {pageBase_reg, commitIdx};
        memWrData_next = pageBuf_reg[commitIdx];
      end
      progCnt_next = progCnt_reg + 32'h1;
      if (progCnt_reg == 32'(PROG_CYCLES - 1))
      begin
        state_next = ST_IDLE;
        pending_next = 1'b0;
        pageVal_next = '0;
      end
    end
    else if (startSeen)
    begin
      // A Start always restarts the byte framing and drops unsent data
      state_next = ST_DEV;
      bitCnt_next = 4'h0;
      ackPhase_next = 1'b0;
      sdaOe_next = 1'b0;
      pending_next = 1'b0;
      pageVal_next = '0;
    end
    else if (stopSeen)
    begin
      sdaOe_next = 1'b0;
      ackPhase_next = 1'b0;
      if (pending_reg)
      begin
        state_next = ST_PROG;
        progCnt_next = 32'h0;
      end
      else
        state_next = ST_IDLE;
    end
    else if (state_reg == ST_RDATA)
    begin
      if (sclRise && bitCnt_reg == `EE_ACK_SLOT)
        mAck_next = !sdaS;
      else if (sclFall && bitCnt_reg < `EE_BYTE_LAST)
      begin
        shift_next = {shift_reg[6:0], 1'b0};
        sdaOe_next = !shift_reg[6];
        bitCnt_next = bitCnt_reg + 4'h1;
      end
      else if (sclFall && bitCnt_reg == `EE_BYTE_LAST)
      begin
        sdaOe_next = 1'b0; // Release for the master's ack slot
        bitCnt_next = `EE_ACK_SLOT;
      end
      else if (sclFall && bitCnt_reg == `EE_ACK_SLOT)
      begin
        if (mAck_reg)
        begin
          // Counter wraps naturally at the array top
          shift_next = memRdData;
          sdaOe_next = !memRdData[7];
          addrCnt_next = addrCnt_reg + 13'h1;
          bitCnt_next = 4'h0;
        end
        else
          state_next = ST_IDLE;
      end
    end
    else if (state_reg != ST_IDLE)
    begin
      if (sclRise && bitCnt_reg < `EE_ACK_SLOT && !ackPhase_reg)
      begin
        shift_next = {shift_reg[6:0], sdaS};
        bitCnt_next = bitCnt_reg + 4'h1;
      end
      else if (sclFall && bitCnt_reg == `EE_ACK_SLOT && !ackPhase_reg)
      begin
        // Whole byte in hand: decide the ack and its side effect
        ackPhase_next = 1'b1;
        sdaOe_next = 1'b1;
        case (state_reg)
          ST_DEV:
          begin
            sdaOe_next = devHit;
            goRead_next = shift_reg[`EE_RW_BIT];
          end
          ST_HI:
            addrHi_next = shift_reg;
          ST_LO:
          begin
            // Dummy write: loads the counter without data
            addrCnt_next = {addrHi_reg[`EE_HI_USED_W-1:0], shift_reg};
            pageBase_next = {addrHi_reg[`EE_HI_USED_W-1:0], shift_reg[7:5]};
            pageVal_next = '0;
          end
          ST_WDATA:
          begin
            // Later bytes at the same slot replace earlier ones
            pageBuf_next[addrCnt_reg[`EE_PAGE_IDX_W-1:0]] = shift_reg;
            pageVal_next[addrCnt_reg[`EE_PAGE_IDX_W-1:0]] = 1'b1;
            addrCnt_next = pageInc(addrCnt_reg);
            pending_next = 1'b1;
          end
          default:
            sdaOe_next = 1'b0;
        endcase
      end
      else if (sclFall && ackPhase_reg)
      begin
        ackPhase_next = 1'b0;
        bitCnt_next = 4'h0;
        sdaOe_next = 1'b0;
        case (state_reg)
          ST_DEV:
          begin
            if (!sdaOe_reg)
              state_next = ST_IDLE;
            else if (goRead_reg)
            begin
              // First byte comes from the counter, which then moves on
              state_next = ST_RDATA;
              mAck_next = 1'b0;
              shift_next = memRdData;
              sdaOe_next = !memRdData[7];
              addrCnt_next = addrCnt_reg + 13'h1;
            end
            else
              state_next = ST_HI;
          end
          ST_HI:
            state_next = ST_LO;
          ST_LO:
            state_next = ST_WDATA;
          ST_WDATA:
            state_next = ST_WDATA;
          default:
            state_next = ST_IDLE;
        endcase
      end
    end
  end

  // Registers of the transfer engine
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      ackPhase_reg <= 1'b0;
      goRead_reg <= 1'b0;
      mAck_reg <= 1'b0;
      shift_reg <= 8'h00;
      addrHi_reg <= 8'h00;
      addrCnt_reg <= 13'h0000;
      sdaOe_reg <= 1'b0;
      pending_reg <= 1'b0;
      pageBase_reg <= 8'h00;
      pageVal_reg <= '0;
      progCnt_reg <= 32'h0;
      memWrEn_reg <= 1'b0;
      memWrAddr_reg <= 13'h0000;
      memWrData_reg <= 8'h00;
      for (int i = 0; i < `EE_PAGE_BYTES; i++)
        pageBuf_reg[i] <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      ackPhase_reg <= ackPhase_next;
      goRead_reg <= goRead_next;
      mAck_reg <= mAck_next;
      shift_reg <= shift_next;
      addrHi_reg <= addrHi_next;
      addrCnt_reg <= addrCnt_next;
      sdaOe_reg <= sdaOe_next;
      pending_reg <= pending_next;
      pageBase_reg <= pageBase_next;
      pageVal_reg <= pageVal_next;
      progCnt_reg <= progCnt_next;
      memWrEn_reg <= memWrEn_next;
      memWrAddr_reg <= memWrAddr_next;
      memWrData_reg <= memWrData_next;
      pageBuf_reg <= pageBuf_next;
    end
  end

  // ===================================================================
  // Outputs, all straight from flops; SDA only ever pulls low
  logic zeroReg;
  logic busyReg;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      zeroReg <= 1'b0;
      busyReg <= 1'b0;
    end
    else
    begin
      zeroReg <= 1'b0;
      busyReg <= state_next == ST_PROG;
    end
  end

  assign sdaOut = zeroReg;
  assign sdaOe = sdaOe_reg;
  assign memAddr = addrCnt_reg;
  assign memWrEn = memWrEn_reg;
  assign memWrAddr = memWrAddr_reg;
  assign memWrData = memWrData_reg;
  assign busy = busyReg;

endmodule : serial_eeprom_i2c_target

// ### tb/eeprom_i2c_asserts.sv
// Purpose: Port-level checker for the two-wire EEPROM target
// Assumes: Bus pins are slow beside core_clk
// Notes: Bound onto every target instance
`timescale 1ns/100ps

module eeprom_i2c_asserts #(
  parameter int unsigned PROG_CYCLES = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus, array and status
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOe,
  input wire logic memWrEn,
  input wire eeprom_i2c_pkg::word_addr_t memWrAddr,
  input wire logic busy
);
  import eeprom_i2c_pkg::*;
  int unsigned progCnt_reg, progCnt_next;
  logic [5:0] wrCnt_reg, wrCnt_next;
  word_addr_t lastWr_reg, lastWr_next;
  logic busyPrev_reg, busyPrev_next;

  // ==================================================================
  // Helpers: programming length and commits of one cycle
  always_comb
  begin
    progCnt_next = busy ? progCnt_reg + 32'h1 : 32'h0;
    busyPrev_next = busy;
    wrCnt_next = (busyPrev_reg && !busy) ? 6'h00 : wrCnt_reg + 6'(memWrEn);
    lastWr_next = memWrEn ? memWrAddr : lastWr_reg;
  end

  // Cleared on reset so a cut cycle leaves no stale count
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      progCnt_reg <= 32'h0;
      wrCnt_reg <= 6'h00;
      lastWr_reg <= 13'h0000;
      busyPrev_reg <= 1'b0;
    end
    else
    begin
      progCnt_reg <= progCnt_next;
      wrCnt_reg <= wrCnt_next;
      lastWr_reg <= lastWr_next;
      busyPrev_reg <= busyPrev_next;
    end
  end

  // ==================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_wr_busy; memWrEn |-> ##[0:1] busy; endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("commit outside programming");
  property p_prog_len;
    $fell(busy) |-> progCnt_reg == PROG_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming length off");
  property p_wr_page;
    memWrEn && wrCnt_reg != 6'h00 |-> memWrAddr[12:5] == lastWr_reg[12:5];
  endproperty
  a_wr_page: assert property (p_wr_page)
    else $error("commit left its page");
  property p_wr_order;
    memWrEn && wrCnt_reg != 6'h00 |-> memWrAddr[4:0] > lastWr_reg[4:0];
  endproperty
  a_wr_order: assert property (p_wr_order)
    else $error("page slot written twice or out of order");
  property p_wr_max; memWrEn |-> wrCnt_reg < 6'h20; endproperty
  a_wr_max: assert property (p_wr_max)
    else $error("more than one page committed");
  property p_busy_quiet; busy |-> !sdaOe; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("bus driven while programming");
  property p_oe_scl_low; $changed(sdaOe) |-> !scl; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("SDA moved while SCL high");
  property p_start_quiet; scl && $fell(sdaIn) |=> !sdaOe [*8]; endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("drive right after Start");
  property p_stop_prog; $rose(busy) |-> scl && sdaIn; endproperty
  a_stop_prog: assert property (p_stop_prog)
    else $error("programming began without Stop");
  c_prog: cover property ($rose(busy));
  c_full_page: cover property (memWrEn && wrCnt_reg == 6'h1f);
  c_prog_end: cover property ($fell(busy));
endmodule : eeprom_i2c_asserts

bind serial_eeprom_i2c_target eeprom_i2c_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaIn), .sdaOe(sdaOe),
  .memWrEn(memWrEn), .memWrAddr(memWrAddr), .busy(busy));

// ### tb/i2c_master_model.sv
// Purpose: Behavioural two-wire bus master
// Assumes: SDA has a pull-up; tasks are called by the bench
// Notes: SCL stands still between frames; a bit takes 160 ns, 100 ns of it low
`timescale 1ns/100ps

module i2c_master_model (
  // Clock
  input wire logic core_clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sdaDrv
);
  // ==================================================================
  // Idle bus: both lines released
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  // Long settle lets the target release SDA before SCL rises
  task automatic start();
    tick(1);
    sdaDrv = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(1);
    sdaDrv = 1'b1;
    tick(8);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
  endtask : stop

  // Data moves one cycle after the fall, never with SCL
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sdaDrv = ~b;
    tick(4);
    scl = 1'b1;
    tick(3);
    s = sda;
    scl = 1'b0;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, nack);
  endtask : wr_byte

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask : rd_byte
endmodule : i2c_master_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the two-wire EEPROM target
// Assumes: Shadow array predicts every byte
// Notes: Commits are checked against a queue by a watcher
`timescale 1ns/100ps

module tb_top;
  import eeprom_i2c_pkg::*;
  localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary type code
  localparam int unsigned PROG_N = 200;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, mstDrv, sdaWire, sdaOut, sdaOe, memWrEn, busy;
  logic [2:0] csBits;
  word_addr_t memAddr, memWrAddr;
  byte_t memRdData, memWrData;
  byte_t mem [8192];
  byte_t model [8192];
  logic [20:0] wrQ [$];
  int err_total = 0;
  int total_checks = 0;

  // ==================================================================
  // Clock, wire and array
  always #10 core_clk = ~core_clk;
  assign sdaWire = !(mstDrv || (sdaOe && !sdaOut));
  assign memRdData = mem[memAddr];

  serial_eeprom_i2c_target #(.DEV_TYPE(TYPE_CODE), .PROG_CYCLES(PROG_N)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .chip_select_bit0(csBits[0]),
    .chip_select_bit1(csBits[1]), .chip_select_bit2(csBits[2]),
    .memAddr(memAddr), .memRdData(memRdData), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .busy(busy));
  i2c_master_model u_mst (.core_clk(core_clk), .sda(sdaWire), .scl(scl), .sdaDrv(mstDrv));

  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Watcher: each commit must be the oldest noted one
  always @(posedge core_clk)
  begin
    if (memWrEn === 1'b1)
    begin
      mem[memWrAddr] <= memWrData;
      if (wrQ.size() == 0)
        chk("stray commit", 21'h1, 21'h0);
      else
        chk("commit", {memWrAddr, memWrData}, wrQ.pop_front());
    end
  end

  // ==================================================================
  // Transfers
  task automatic addr_byte(input logic rw, input logic expNack);
    logic n;
    u_mst.start();
    u_mst.wr_byte({TYPE_CODE, csBits, rw}, n);
    chk("address ack", n, expNack);
  endtask : addr_byte

  task automatic send(input byte_t d);
    logic n;
    u_mst.wr_byte(d, n);
    chk("byte ack", n, 1'b0);
  endtask : send

  // Acks all but the last byte, then Stop
  task automatic read_seq(input word_addr_t a, input int cnt);
    byte_t d;
    for (int i = 0; i < cnt; i++)
    begin
      u_mst.rd_byte(i < cnt - 1, d);
      chk("read", d, model[word_addr_t'(a + i)]);
    end
    u_mst.stop();
  endtask : read_seq

  task automatic rnd_read(input word_addr_t a, input int cnt);
    addr_byte(1'b0, 1'b0);
    send({3'h0, a[12:8]});
    send(a[7:0]);
    addr_byte(1'b1, 1'b0);
    read_seq(a, cnt);
  endtask : rnd_read

  // Bounded acknowledge polling; a write that never ends fails the run
  task automatic poll_done();
    logic n;
    n = 1'b1;
    for (int i = 0; i < 10 && n === 1'b1; i++)
    begin
      u_mst.start();
      u_mst.wr_byte({TYPE_CODE, csBits, 1'b0}, n);
    end
    chk("poll done", n, 1'b0);
    if (n !== 1'b0)
      wrap_up();
    u_mst.stop();
    chk("commits left", 21'(wrQ.size()), 21'h0);
  endtask : poll_done

  // ==================================================================
  // Main sequence
  initial
  begin
    byte_t d;
    logic n;
    word_addr_t pg;
    byte_t slot [32];
    d = 8'($urandom(80));
    csBits = 3'($urandom);
    for (int i = 0; i < 8192; i++)
    begin
      mem[i] = 8'($urandom);
      model[i] = mem[i];
    end
    repeat (2) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    u_mst.tick(4);
    // Each type and select bit wrong once
    for (int i = 1; i < 8; i++)
    begin
      u_mst.start();
      u_mst.wr_byte({TYPE_CODE, csBits, 1'b0} ^ (8'h01 << i), n);
      chk("bad address", n, 1'b1);
      u_mst.stop();
    end
    $display("test bad address done");
    // 34 bytes from offset 30: wraps and overwrites
    pg = {8'($urandom), 5'h1e};
    addr_byte(1'b0, 1'b0);
    send({3'h7, pg[12:8]});
    send(pg[7:0]);
    for (int k = 0; k < 34; k++)
    begin
      d = 8'($urandom);
      slot[5'(k + 30)] = d;
      send(d);
    end
    for (int s = 0; s < 32; s++)
    begin
      model[{pg[12:5], 5'(s)}] = slot[s];
      wrQ.push_back({pg[12:5], 5'(s), slot[s]});
    end
    u_mst.stop();
    $display("test page write done");
    u_mst.start();
    chk("busy", busy, 1'b1);
    u_mst.wr_byte({TYPE_CODE, csBits, 1'b0}, n);
    chk("poll while busy", n, 1'b1);
    poll_done();
    $display("test polling done");
    addr_byte(1'b1, 1'b0);
    read_seq({pg[12:5], 5'h00}, 1);
    rnd_read({pg[12:5], 5'h00}, 32);
    rnd_read(13'h1fff, 1);
    addr_byte(1'b1, 1'b0);
    read_seq(13'h0000, 2);
    rnd_read(13'h1fff, 3);
    $display("test reads done");
    // Single byte: only its slot commits, counter moves on within the page
    pg = 13'($urandom);
    d = 8'($urandom);
    addr_byte(1'b0, 1'b0);
    send({3'h0, pg[12:8]});
    send(pg[7:0]);
    send(d);
    model[pg] = d;
    wrQ.push_back({pg, d});
    u_mst.stop();
    poll_done();
    addr_byte(1'b1, 1'b0);
    read_seq({pg[12:5], pg[4:0] + 5'h01}, 1);
    rnd_read(pg, 1);
    $display("test byte write done");
    // Repeated Start in mid-write must discard the data
    addr_byte(1'b0, 1'b0);
    send(8'h00);
    send(8'h40);
    send(8'ha5);
    addr_byte(1'b0, 1'b0);
    u_mst.stop();
    u_mst.tick(50);
    chk("no program", busy, 1'b0);
    $display("test abort done");
    wrap_up();
  end
endmodule : tb_top
